// ---- core/adcs_device.sv ----
`timescale 1ns/1ps
`include "adcs_defs.svh"

// Contract
// - codes 0-4 route analog inputs 0-4
// - codes B,C,D select internal self-tests
// - self-tests return 200, 000, 3FF
// - framed self-tests read 8000, 0000, FFC0
// - only top four outbound bits matter
// - result in ten MSBs, six zeros
// - accept sixteen clocks or two bursts
// - full duplex: address in, result out
// - conversion-complete output marks ready result
// - host may read on conversion-complete interrupt
// - result is previous; address is next
// - address MSB first, first four rises
// - result MSB first, zeros from tenth fall
// - eoc low tenth fall, high when done
// - select high holds serial port in reset
module adcs_device (
    // conversion clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // link to the host
    adcs_link_if.dev              link,
    // digitised analog inputs, synchronous to clock
    input  wire adcs_pkg::adcs_res_t analog_in_0,
    input  wire adcs_pkg::adcs_res_t analog_in_1,
    input  wire adcs_pkg::adcs_res_t analog_in_2,
    input  wire adcs_pkg::adcs_res_t analog_in_3,
    input  wire adcs_pkg::adcs_res_t analog_in_4,
    // status
    output logic                  conv_busy
);

    adcs_pkg::adcs_rise_t rise_ff;
    adcs_pkg::adcs_rise_t nxt_rise;
    adcs_pkg::adcs_addr_t addr_ff;
    adcs_pkg::adcs_addr_t nxt_addr;
    adcs_pkg::adcs_fall_t fall_ff;
    adcs_pkg::adcs_fall_t nxt_fall;
    adcs_pkg::adcs_core_t core_ff;
    adcs_pkg::adcs_core_t nxt_core;
    logic                 port_rst;
    logic                 held_rise;
    logic                 cs_fall;

    // rising edge seen on the last two stages of a three-stage synchroniser
    function automatic logic sync_rise(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction : sync_rise

    // channel decode: five digitised inputs and three fixed self-test levels;
    // unlisted codes are the host's fault, and converting zero keeps the port in step
    function automatic adcs_pkg::adcs_res_t sel_sample(input adcs_pkg::adcs_sel_t sel,
                                                       input adcs_pkg::adcs_res_t in0,
                                                       input adcs_pkg::adcs_res_t in1,
                                                       input adcs_pkg::adcs_res_t in2,
                                                       input adcs_pkg::adcs_res_t in3,
                                                       input adcs_pkg::adcs_res_t in4);
        adcs_pkg::adcs_res_t res;
        case (sel)
            `ADCS_SEL_IN0:  res = in0;
            `ADCS_SEL_IN1:  res = in1;
            `ADCS_SEL_IN2:  res = in2;
            `ADCS_SEL_IN3:  res = in3;
            `ADCS_SEL_IN4:  res = in4;
            `ADCS_SEL_HALF: res = `ADCS_TEST_HALF;
            `ADCS_SEL_ZERO: res = `ADCS_TEST_ZERO;
            `ADCS_SEL_FULL: res = `ADCS_TEST_FULL;
            default:        res = `ADCS_TEST_ZERO;
        endcase
        return res;
    endfunction : sel_sample

    // result bit on the data line after a given number of falls: msb first,
    // zeros once all ten bits are out
    function automatic logic frame_bit(input adcs_pkg::adcs_res_t res,
                                       input logic [3:0]          falls);
        logic bit_out;
        if (falls > `ADCS_LAST_FALL) begin
            bit_out = 1'b0;
        end else begin
            bit_out = res[4'h9 - falls];
        end
        return bit_out;
    endfunction : frame_bit

    // limitation: no glitch filter on select, so a noisy select line resets the port
    // the link clock stops with select high, so select itself clears the port
    assign port_rst = rst | link.cs_n;

    // ---------------- link domain, rising edges ----------------
    always_comb begin
        nxt_rise      = rise_ff;
        nxt_rise.rcnt = rise_ff.rcnt + 4'h1;
        nxt_addr      = addr_ff;
        // later bits on the input line are don't-care
        if (rise_ff.rcnt < `ADCS_ADDR_EDGES) begin
            nxt_addr.addr = {addr_ff.addr[2:0], link.din};
        end
    end

    always_ff @(posedge link.sclk or posedge port_rst) begin
        if (port_rst) begin
            rise_ff <= '0;
        end else begin
            rise_ff <= nxt_rise;
        end
    end

    // address survives select going high: the core picks it up a few clocks
    // after the tenth fall, which may be after the host has deselected
    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            addr_ff <= '0;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // ---------------- link domain, falling edges ----------------
    always_comb begin
        nxt_fall      = fall_ff;
        // four bits wrap at sixteen, so an unbroken 16-clock stream with
        // select held low starts the next frame by itself
        nxt_fall.fcnt = fall_ff.fcnt + 4'h1;
        if (fall_ff.fcnt == `ADCS_LAST_FALL) begin
            nxt_fall.held = 1'b1;
        end else if (fall_ff.fcnt == `ADCS_WRAP_FALL) begin
            nxt_fall.held = 1'b0;
        end
    end

    always_ff @(negedge link.sclk or posedge port_rst) begin
        if (port_rst) begin
            fall_ff <= '0;
        end else begin
            fall_ff <= nxt_fall;
        end
    end

    // the result word is quasi-static: the core only rewrites it at the end
    // of a conversion, while eoc is low and no read is legal
    always_comb begin
        link.dout = frame_bit(core_ff.result, fall_ff.fcnt);
    end

    // released whenever select is high; the carrier pulls the line up then
    assign link.dout_oe = ~link.cs_n;

    // ---------------- conversion domain ----------------
    // with select raised right after the tenth fall the hold flag lives for one
    // clock only; three stages catch it because the host derives the link clock
    // from this same clock, which an unrelated link clock would not guarantee
    assign held_rise = sync_rise(core_ff.held_sync);
    assign cs_fall   = sync_rise(~core_ff.cs_sync);

    always_comb begin
        nxt_core           = core_ff;
        nxt_core.held_sync = {core_ff.held_sync[1:0], fall_ff.held};
        nxt_core.cs_sync   = {core_ff.cs_sync[1:0], link.cs_n};
        case (core_ff.state)
            adcs_pkg::DEV_IDLE: begin
                // hold phase begins at the tenth fall; sample the chosen input
                if (held_rise) begin
                    nxt_core.eoc    = 1'b0;
                    nxt_core.timer  = 11'(`ADCS_CONV_CYC - 1);
                    nxt_core.state  = adcs_pkg::DEV_CONV;
                    nxt_core.sample = sel_sample(addr_ff.addr, analog_in_0, analog_in_1,
                                                 analog_in_2, analog_in_3, analog_in_4);
                end
            end
            adcs_pkg::DEV_CONV: begin
                if (cs_fall) begin
                    // reselect mid-conversion aborts; old result stays
                    nxt_core.eoc   = 1'b1;
                    nxt_core.state = adcs_pkg::DEV_IDLE;
                end else if (core_ff.timer == 11'h000) begin
                    nxt_core.result = core_ff.sample;
                    nxt_core.eoc    = 1'b1;
                    nxt_core.state  = adcs_pkg::DEV_IDLE;
                end else begin
                    nxt_core.timer = core_ff.timer - 11'h001;
                end
            end
            default: begin
                nxt_core.state = adcs_pkg::DEV_IDLE;
                nxt_core.eoc   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_ff.state     <= adcs_pkg::DEV_IDLE;
            core_ff.held_sync <= 3'h0;
            core_ff.cs_sync   <= 3'h7;
            core_ff.sample    <= `ADCS_RES_RESET;
            core_ff.result    <= `ADCS_RES_RESET;
            core_ff.timer     <= 11'h000;
            core_ff.eoc       <= 1'b1;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign link.eoc  = core_ff.eoc;
    assign conv_busy = (core_ff.state == adcs_pkg::DEV_CONV);

endmodule : adcs_device

// ---- core/adcs_defs.svh ----
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// widths
`define ADCS_SEL_W        4
`define ADCS_RES_W        10
`define ADCS_FRAME_W      16

// channel-select codes
`define ADCS_SEL_IN0      4'h0
`define ADCS_SEL_IN1      4'h1
`define ADCS_SEL_IN2      4'h2
`define ADCS_SEL_IN3      4'h3
`define ADCS_SEL_IN4      4'h4
`define ADCS_SEL_HALF     4'hb
`define ADCS_SEL_ZERO     4'hc
`define ADCS_SEL_FULL     4'hd

// self-test and reset results
`define ADCS_TEST_HALF    10'h200
`define ADCS_TEST_ZERO    10'h000
`define ADCS_TEST_FULL    10'h3ff
`define ADCS_RES_RESET    10'h000

// framing edge counts
`define ADCS_ADDR_EDGES   4'h4
`define ADCS_LAST_FALL    4'h9
`define ADCS_WRAP_FALL    4'hf
`define ADCS_BITS_SHORT   5'h0a
`define ADCS_BITS_LONG    5'h10
`define ADCS_BITS_BURST   5'h08

// timing
`define ADCS_CLK_NS       25
`define ADCS_CONV_NS      44000
`define ADCS_CONV_CYC     (`ADCS_CONV_NS / `ADCS_CLK_NS)
`define ADCS_SCLK_HALF_NS 100
`define ADCS_HALF_CYC     ((`ADCS_SCLK_HALF_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_CS_SETUP_NS  2000
`define ADCS_CS_CYC       ((`ADCS_CS_SETUP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_GAP_NS       500
`define ADCS_GAP_CYC      ((`ADCS_GAP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

`endif

// ---- core/adcs_pkg.sv ----
package adcs_pkg;

    typedef logic [3:0] adcs_sel_t;
    typedef logic [9:0] adcs_res_t;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_CONV = 2'b10
    } adcs_dev_state_t;

    typedef enum logic [5:0] {
        HST_IDLE  = 6'h01,
        HST_SETUP = 6'h02,
        HST_LOW   = 6'h04,
        HST_HIGH  = 6'h08,
        HST_GAP   = 6'h10,
        HST_END   = 6'h20
    } adcs_hst_state_t;

    typedef struct packed {
        logic [3:0] rcnt;
    } adcs_rise_t;

    typedef struct packed {
        adcs_sel_t addr;
    } adcs_addr_t;

    typedef struct packed {
        logic [3:0] fcnt;
        logic       held;
    } adcs_fall_t;

    typedef struct packed {
        adcs_dev_state_t state;
        logic [2:0]      held_sync;
        logic [2:0]      cs_sync;
        adcs_res_t       sample;
        adcs_res_t       result;
        logic [10:0]     timer;
        logic            eoc;
    } adcs_core_t;

    typedef struct packed {
        adcs_hst_state_t state;
        logic [7:0]      timer;
        logic [4:0]      bits;
        logic [15:0]     shout;
        logic [15:0]     shin;
        logic            len16;
        logic            split;
        logic            sclk;
        logic            cs_n;
        logic [1:0]      dout_sync;
        logic [1:0]      eoc_sync;
        adcs_res_t       result;
        logic            valid;
    } adcs_host_t;

endpackage : adcs_pkg

// ---- core/adcs_link_if.sv ----
`timescale 1ns/1ps
interface adcs_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;
    logic eoc;

    // released data line idles high
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input  sclk,
        input  cs_n,
        input  din,
        output dout,
        output dout_oe,
        output eoc
    );

    modport host (
        output sclk,
        output cs_n,
        output din,
        input  dout_line,
        input  eoc
    );
endinterface : adcs_link_if

// ---- core/adcs_host.sv ----
`timescale 1ns/1ps
`include "adcs_defs.svh"

module adcs_host (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // link to the converter
    adcs_link_if.host             link,
    // request side
    input  wire logic             req,
    input  wire adcs_pkg::adcs_sel_t req_addr,
    input  wire logic             req_len16,
    input  wire logic             req_split,
    output logic                  ready,
    // answer side
    output adcs_pkg::adcs_res_t   result_data,
    output logic                  result_valid,
    output logic                  eoc_irq
);

    adcs_pkg::adcs_host_t q_ff;
    adcs_pkg::adcs_host_t nxt_q;
    logic [4:0]           last_bit;

    assign last_bit = q_ff.len16 ? `ADCS_BITS_LONG : `ADCS_BITS_SHORT;

    always_comb begin
        nxt_q           = q_ff;
        nxt_q.valid     = 1'b0;
        nxt_q.dout_sync = {q_ff.dout_sync[0], link.dout_line};
        nxt_q.eoc_sync  = {q_ff.eoc_sync[0], link.eoc};
        case (q_ff.state)
            adcs_pkg::HST_IDLE: begin
                nxt_q.sclk = 1'b0;
                nxt_q.cs_n = 1'b1;
                if (req) begin
                    // low twelve bits are don't-care; a non-zero pattern there
                    // keeps the converter's ignoring of them exercised
                    nxt_q.shout = {req_addr, ~req_addr, req_addr, ~req_addr};
                    nxt_q.shin  = 16'h0000;
                    nxt_q.len16 = req_len16;
                    nxt_q.split = req_split & req_len16;
                    nxt_q.bits  = 5'h00;
                    nxt_q.cs_n  = 1'b0;
                    nxt_q.timer = 8'(`ADCS_CS_CYC - 1);
                    nxt_q.state = adcs_pkg::HST_SETUP;
                end
            end
            adcs_pkg::HST_SETUP,
            adcs_pkg::HST_GAP: begin
                if (q_ff.timer == 8'h00) begin
                    nxt_q.timer = 8'(`ADCS_HALF_CYC - 1);
                    nxt_q.state = adcs_pkg::HST_LOW;
                end else begin
                    nxt_q.timer = q_ff.timer - 8'h01;
                end
            end
            adcs_pkg::HST_LOW: begin
                if (q_ff.timer == 8'h00) begin
                    // sample just before the rise, where the device has held
                    // its bit for a whole low phase
                    nxt_q.sclk  = 1'b1;
                    nxt_q.shin  = {q_ff.shin[14:0], q_ff.dout_sync[1]};
                    nxt_q.timer = 8'(`ADCS_HALF_CYC - 1);
                    nxt_q.state = adcs_pkg::HST_HIGH;
                end else begin
                    nxt_q.timer = q_ff.timer - 8'h01;
                end
            end
            adcs_pkg::HST_HIGH: begin
                if (q_ff.timer == 8'h00) begin
                    nxt_q.sclk  = 1'b0;
                    nxt_q.shout = {q_ff.shout[14:0], 1'b0};
                    nxt_q.bits  = q_ff.bits + 5'h01;
                    nxt_q.timer = 8'(`ADCS_HALF_CYC - 1);
                    nxt_q.state = adcs_pkg::HST_LOW;
                    if (nxt_q.bits == last_bit) begin
                        nxt_q.result = q_ff.len16 ? q_ff.shin[15:6] : q_ff.shin[9:0];
                        nxt_q.timer  = 8'(`ADCS_CS_CYC - 1);
                        nxt_q.state  = adcs_pkg::HST_END;
                    end else if (q_ff.split && nxt_q.bits == `ADCS_BITS_BURST) begin
                        nxt_q.timer = 8'(`ADCS_GAP_CYC - 1);
                        nxt_q.state = adcs_pkg::HST_GAP;
                    end
                end else begin
                    nxt_q.timer = q_ff.timer - 8'h01;
                end
            end
            adcs_pkg::HST_END: begin
                // deselect long enough for the converter to see it
                nxt_q.cs_n = 1'b1;
                if (q_ff.timer == 8'h00) begin
                    nxt_q.valid = 1'b1;
                    nxt_q.state = adcs_pkg::HST_IDLE;
                end else begin
                    nxt_q.timer = q_ff.timer - 8'h01;
                end
            end
            default: begin
                nxt_q.state = adcs_pkg::HST_IDLE;
                nxt_q.cs_n  = 1'b1;
                nxt_q.sclk  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_ff       <= '0;
            q_ff.state <= adcs_pkg::HST_IDLE;
            q_ff.cs_n  <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign link.sclk    = q_ff.sclk;
    assign link.cs_n    = q_ff.cs_n;
    assign link.din     = q_ff.shout[15];
    assign ready        = (q_ff.state == adcs_pkg::HST_IDLE);
    assign result_data  = q_ff.result;
    assign result_valid = q_ff.valid;
    assign eoc_irq      = q_ff.eoc_sync[1];

endmodule : adcs_host

// ---- testbench/adcs_link_assertions.sv ----
`timescale 1ns/1ps
module adcs_link_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic dout_line,
    input wire logic eoc
);
    typedef struct packed {
        logic        sclk_q;
        logic [4:0]  falls;
        logic [11:0] low_cnt;
    } adcs_chk_t;

    adcs_chk_t st_ff;
    adcs_chk_t nxt_st;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // falls are counted per selected transfer, so a port reset restarts the count
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_q = sclk;
        nxt_st.low_cnt = eoc ? 12'h000 : st_ff.low_cnt + 12'h001;
        if (cs_n) nxt_st.falls = 5'h00;
        else if (st_ff.sclk_q && !sclk) nxt_st.falls = st_ff.falls + 5'h01;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) st_ff <= '0;
        else st_ff <= nxt_st;
    end

    sequence s_tenth_fall;
        !cs_n && eoc && $fell(sclk) && (st_ff.falls == 5'h09);
    endsequence

    sequence s_high4;
        sclk [*4] ##1 !sclk;
    endsequence

    AST_OE_BY_SELECT: assert property (dout_oe == !cs_n)
        else $error("data output enable does not follow select");
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("serial clock runs outside a transfer");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high4)
        else $error("serial clock high phase has wrong length");
    AST_DIN_STABLE: assert property ($changed(din) && !cs_n |-> !sclk)
        else $error("address line changed while clock high");
    AST_ZERO_TAIL: assert property ($rose(sclk) && !cs_n && (st_ff.falls >= 5'h0a) |-> (dout == 1'b0))
        else $error("data output not low after tenth fall");
    AST_EOC_FALL: assert property (s_tenth_fall |-> ##[1:6] !eoc)
        else $error("conversion flag did not drop after tenth fall");
    AST_EOC_LOW8: assert property ($fell(eoc) |-> !eoc [*8])
        else $error("conversion flag glitched high");
    // the window tolerates either reading of where the conversion count starts
    AST_CONV_TIME: assert property ($rose(eoc) && cs_n |-> (st_ff.low_cnt > 12'h6c0) && (st_ff.low_cnt < 12'h700))
        else $error("conversion time out of range");
    AST_LINE_RELEASE: assert property (dout_line == (cs_n ? 1'b1 : dout))
        else $error("data line not released high while deselected");
endmodule : adcs_link_assertions

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    localparam int LIMIT = 60000;

    logic                clock;
    logic                rst;
    logic                req;
    adcs_pkg::adcs_sel_t req_addr;
    logic                req_len16;
    logic                req_split;
    logic                ready;
    adcs_pkg::adcs_res_t result_data;
    logic                result_valid;
    logic                eoc_irq;
    logic                conv_busy;
    adcs_pkg::adcs_res_t ana [5];
    adcs_pkg::adcs_res_t prev_exp;
    adcs_pkg::adcs_sel_t corner [8] = '{4'hb, 4'hc, 4'hd, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    logic [31:0]         lfsr;
    logic [15:0]         dcap;
    logic [15:0]         icap;
    int                  rises;
    int                  cycles;
    int                  fails;
    int                  checked;

    adcs_link_if adcs_link_if_i ();

    adcs_device adcs_device_i (.clock(clock), .rst(rst), .link(adcs_link_if_i), .analog_in_0(ana[0]),
        .analog_in_1(ana[1]), .analog_in_2(ana[2]), .analog_in_3(ana[3]), .analog_in_4(ana[4]),
        .conv_busy(conv_busy));

    adcs_host adcs_host_i (.clock(clock), .rst(rst), .link(adcs_link_if_i), .req(req), .req_addr(req_addr),
        .req_len16(req_len16), .req_split(req_split), .ready(ready), .result_data(result_data),
        .result_valid(result_valid), .eoc_irq(eoc_irq));

    adcs_link_assertions chk_i (.clock(clock), .rst(rst), .sclk(adcs_link_if_i.sclk),
        .cs_n(adcs_link_if_i.cs_n), .din(adcs_link_if_i.din), .dout(adcs_link_if_i.dout),
        .dout_oe(adcs_link_if_i.dout_oe), .dout_line(adcs_link_if_i.dout_line), .eoc(adcs_link_if_i.eoc));

    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    // wire-level capture, independent of the host's own shift registers
    always @(posedge adcs_link_if_i.sclk) begin
        dcap = {dcap[14:0], adcs_link_if_i.dout_line};
        icap = {icap[14:0], adcs_link_if_i.din};
        rises = rises + 1;
    end

    always @(negedge adcs_link_if_i.cs_n) begin
        dcap = 16'h0000;
        icap = 16'h0000;
        rises = 0;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction : lfsr_next

    function automatic adcs_pkg::adcs_res_t expect_res(input adcs_pkg::adcs_sel_t c);
        case (c)
            4'hb: return 10'h200;
            4'hc: return 10'h000;
            4'hd: return 10'h3ff;
            default: return ana[c[2:0]];
        endcase
    endfunction : expect_res

    task automatic check_res(input adcs_pkg::adcs_res_t got, input adcs_pkg::adcs_res_t exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_res

    task automatic check_frame(input logic [15:0] got, input logic [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_frame

    task automatic check_bit(input logic got, input logic exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic print_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // one exchange: the answer is the previous channel, the code picks the next one
    task automatic xfer(input adcs_pkg::adcs_sel_t code, input logic l16, input logic spl, input logic wait_eoc);
        int n;
        @(posedge clock);
        req       <= 1'b1;
        req_addr  <= code;
        req_len16 <= l16;
        req_split <= spl;
        @(posedge clock);
        req <= 1'b0;
        @(negedge clock);
        check_bit(ready, 1'b0);
        n = 0;
        while (result_valid !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check_bit(result_valid, 1'b1);
        check_bit(ready, 1'b1);
        check_res(result_data, prev_exp);
        check_frame(dcap, l16 ? {prev_exp, 6'h00} : {6'h00, prev_exp});
        check_frame({12'h000, icap[rises - 1 -: 4]}, {12'h000, code});
        check_bit(eoc_irq, 1'b0);
        check_bit(conv_busy, 1'b1);
        // a conversion cut short by the next reselect leaves the older result in place
        if (wait_eoc) begin
            prev_exp = expect_res(code);
        end
        // inputs move only after the sample point of the running conversion
        @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            ana[i] <= lfsr[9:0];
        end
        if (wait_eoc) begin
            n = 0;
            while (eoc_irq !== 1'b1 && n < 2500) begin
                @(negedge clock);
                n++;
            end
            check_bit(eoc_irq, 1'b1);
        end
    endtask : xfer

    initial begin
        rst       = 1'b1;
        req       = 1'b0;
        req_addr  = 4'h0;
        req_len16 = 1'b0;
        req_split = 1'b0;
        lfsr      = 32'hf3d8;
        prev_exp  = 10'h000;
        cycles    = 0;
        fails     = 0;
        checked   = 0;
        rises     = 0;
        dcap      = 16'h0000;
        icap      = 16'h0000;
        ana[0]    = 10'h3ff;
        ana[1]    = 10'h000;
        ana[2]    = 10'h155;
        ana[3]    = 10'h2aa;
        ana[4]    = 10'h001;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) xfer(corner[k], k[0], k[1], 1'b1);
        // reselect during a conversion: the next read returns the result before it
        xfer(4'h2, 1'b1, 1'b0, 1'b0);
        xfer(4'hb, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 9; k++) begin
            lfsr = lfsr_next(lfsr);
            xfer(corner[lfsr[2:0]], lfsr[3], lfsr[4], 1'b1);
        end
        print_verdict();
    end
endmodule : tb_top
